// [nth_regs.svh]
// Constants for the target-mode command handler: opcodes, status codes,
// limits, timing and the small register port map.
// Assumes inclusion by bare name from design, checker and bench files.
`ifndef NTH_REGS_SVH
`define NTH_REGS_SVH

// Host command opcodes and their response codes
`define NTH_CMD_GB_LOAD 8'h92
`define NTH_RSP_GB_LOAD 8'h93
`define NTH_CMD_RECEIVE 8'h86
`define NTH_RSP_RECEIVE 8'h87
`define NTH_CMD_SEND 8'h8E
`define NTH_RSP_SEND 8'h8F
`define NTH_CMD_PARTIAL 8'h94
`define NTH_RSP_PARTIAL 8'h95
`define NTH_RSP_UNKNOWN 8'h00

// Status byte values and fields
`define NTH_ST_OK 8'h00
`define NTH_ST_BAD_STATE 8'h25
`define NTH_ST_RELEASED 8'h29
`define NTH_ST_SYNTAX 8'h27
`define NTH_ST_NADDR_BIT 7
`define NTH_ST_MINFO_BIT 6

// Length limits in bytes
`define NTH_GB_MAX 9'h02F
`define NTH_PAYLOAD_MAX 9'h106

// Time extension: multiplier, base wait time in ms, clock in kHz
`define NTH_WTX_MULT 8'h07
`define NTH_WAIT_MS 154
`define NTH_CLK_KHZ 40000

// Register port map
`define NTH_REG_CTRL 2'h0
`define NTH_REG_STATUS 2'h1
`define NTH_CTRL_AUTO_BIT 0
`define NTH_CTRL_EXCL_BIT 1
`define NTH_CTRL_RESET 2'h1
`define NTH_STAT_READY_BIT 0
`define NTH_STAT_HOLD_BIT 1
`define NTH_STAT_BUSY_BIT 2

`endif

// [nth_pkg.sv]
// Types shared by the target-mode command handler.
// Assumes nth_regs.svh is on the include path.
package nth_pkg;
  typedef enum logic [6:0] {
    NTH_S_IDLE = 7'h01,
    NTH_S_FWD = 7'h02,
    NTH_S_DRAIN = 7'h04,
    NTH_S_RXWAIT = 7'h08,
    NTH_S_RESP = 7'h10,
    NTH_S_SPARE1 = 7'h20,
    NTH_S_SPARE2 = 7'h40
  } nth_state_t;
endpackage

// [nth_frame_store.sv]
// Byte store for one received RF frame, held until the host fetches it.
// Assumes writes and reads come from the same clock; read is unclocked.
`timescale 1ns/1ps
module nth_frame_store #(
  parameter int W = 8,
  parameter int DEPTH = 262,
  parameter int AW = 9
) (
  input wire logic i_clk,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Out-of-range reads return zero rather than an undefined word
  always_comb begin
    o_rd_data = '0;
    if (i_rd_addr < AW'(DEPTH)) begin
      o_rd_data = mem[i_rd_addr];
    end
  end
endmodule

// [nth_target_cmd.sv]
// Target-mode command handler between the host link and the RF framer.
// Assumes host and RF framer run on i_clk and the host always takes
// response bytes; RF chaining and retries live in the RF framer.
//
// What this block does
// - General bytes longer than 47 are refused with a syntax error; with auto reply set they are drained with status 00.
// - General-bytes load is refused as unsupported in PICC emulation.
// - Auto attribute reply set: reply uses bytes from target init.
// - Auto reply clear: hold reply until loaded bytes arrive, then send.
// - Receive answers code 87, status, then 0 to 262 payload bytes.
// - In DEP the status flags node address and more-information.
// - Receive first acks the host, then waits unbounded for a frame.
// - PICC: after a full frame send wait extension, multiplier 7.
// - After the extension, forward the frame as receive payload.
// - DEP: accept frames early, keep link alive with extensions.
// - PICC: accept blocks early, keep link alive with extensions.
// - Receive outside DEP and PICC returns status 25.
// - Receive after release returns status 29.
// - Send is code 8E with 0 to 262 reply bytes in one frame.
// - Send reply goes to RF; chaining and recovery stay internal.
// - Partial send 94/95 is DEP only; refused in PICC emulation.
// - Partial send marks more-information in the last packet.
// - Exclusive-protocol mode refuses odd frames, restarts anticollision.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "nth_regs.svh"
module nth_target_cmd import nth_pkg::*; #(
  parameter int DEPTH = 262,
  parameter int P_WTX_CYCLES = `NTH_WAIT_MS * `NTH_WTX_MULT * `NTH_CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_cmd_last,
  output logic o_host_valid,
  output logic [7:0] o_host_byte,
  output logic o_host_last,
  output logic o_host_ack,
  input wire logic i_dep_active,
  input wire logic i_picc_active,
  input wire logic i_released,
  input wire logic i_atr_pending,
  input wire logic i_rf_rx_valid,
  input wire logic [7:0] i_rf_rx_byte,
  input wire logic i_rf_rx_last,
  input wire logic i_rf_rx_naddr,
  input wire logic i_rf_rx_minfo,
  input wire logic i_rf_prop_frame,
  output logic o_rf_tx_valid,
  output logic [7:0] o_rf_tx_byte,
  output logic o_rf_tx_gb,
  output logic o_rf_tx_end,
  output logic o_rf_tx_more,
  output logic o_rf_tx_abort,
  output logic o_atr_send,
  output logic o_atr_hold,
  output logic o_wtx_req,
  output logic [7:0] o_wtx_mult,
  output logic o_anticoll_restart,
  input wire logic [1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata
);
  // ==========================================================
  // State
  // ==========================================================
  nth_state_t state_reg, state_next;
  logic [7:0] rsp_reg, rsp_next;
  logic [7:0] st_reg, st_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [8:0] pay_reg, pay_next;
  logic gb_reg, gb_next;
  logic more_reg, more_next;
  logic rxcmd_reg, rxcmd_next;
  logic hv_reg, hv_next, hl_reg, hl_next, ack_reg, ack_next;
  logic [7:0] hb_reg, hb_next;
  logic tv_reg, tv_next, tgb_reg, tgb_next, te_reg, te_next;
  logic tm_reg, tm_next, ta_reg, ta_next, as_reg, as_next;
  logic [7:0] tb_reg, tb_next;
  logic hold_reg, hold_next, ac_reg, ac_next;
  logic [8:0] wa_reg, wa_next, flen_reg, flen_next;
  logic rdy_reg, rdy_next, naddr_reg, naddr_next, minfo_reg, minfo_next;
  logic wtx_reg, wtx_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [15:0] rd_reg, rd_next;
  logic mem_wr;
  logic [8:0] mem_ra;
  logic [7:0] mem_rd;
  logic auto_f, excl_f, proto_ok;
  logic [8:0] lim;

  assign auto_f = ctrl_reg[`NTH_CTRL_AUTO_BIT];
  assign excl_f = ctrl_reg[`NTH_CTRL_EXCL_BIT];
  assign proto_ok = i_dep_active | i_picc_active;

  nth_frame_store #(.W(8), .DEPTH(DEPTH), .AW(9)) u_store (
    .i_clk(i_clk),
    .i_wr_en(mem_wr),
    .i_wr_addr(wa_reg),
    .i_wr_data(i_rf_rx_byte),
    .i_rd_addr(mem_ra),
    .o_rd_data(mem_rd)
  );

  // ==========================================================
  // RF receive capture and keep-alive
  // ==========================================================
  // A held frame blocks new capture, so an unread frame is never
  // overwritten; the initiator is kept waiting by extensions instead.
  always_comb begin
    wa_next = wa_reg;
    flen_next = flen_reg;
    rdy_next = rdy_reg;
    naddr_next = naddr_reg;
    minfo_next = minfo_reg;
    wtx_next = 1'b0;
    tmr_next = tmr_reg;
    ac_next = 1'b0;
    mem_wr = 1'b0;
    if (i_rf_prop_frame && excl_f) begin
      ac_next = 1'b1;
    end
    if (state_reg == NTH_S_RESP && rxcmd_reg && hv_reg && hl_reg) begin
      rdy_next = 1'b0;
    end
    if (i_rf_rx_valid && !rdy_reg && !i_rf_prop_frame) begin
      mem_wr = (wa_reg < 9'(DEPTH));
      wa_next = wa_reg + 9'h001;
      if (i_rf_rx_last) begin
        rdy_next = 1'b1;
        flen_next = mem_wr ? wa_reg + 9'h001 : wa_reg;
        wa_next = 9'h000;
        naddr_next = i_rf_rx_naddr;
        minfo_next = i_rf_rx_minfo;
        wtx_next = proto_ok;
        tmr_next = 32'(P_WTX_CYCLES - 1);
      end
    end else if (rdy_reg) begin
      if (tmr_reg == 32'h0000_0000) begin
        wtx_next = proto_ok;
        tmr_next = 32'(P_WTX_CYCLES - 1);
      end else begin
        tmr_next = tmr_reg - 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // Command sequencer
  // ==========================================================
  always_comb begin
    state_next = state_reg;
    rsp_next = rsp_reg;
    st_next = st_reg;
    cnt_next = cnt_reg;
    pay_next = pay_reg;
    gb_next = gb_reg;
    more_next = more_reg;
    rxcmd_next = rxcmd_reg;
    hv_next = 1'b0;
    hb_next = hb_reg;
    hl_next = 1'b0;
    ack_next = 1'b0;
    tv_next = 1'b0;
    tb_next = tb_reg;
    tgb_next = tgb_reg;
    te_next = 1'b0;
    tm_next = tm_reg;
    ta_next = 1'b0;
    as_next = 1'b0;
    mem_ra = 9'h000;
    lim = gb_reg ? `NTH_GB_MAX : `NTH_PAYLOAD_MAX;
    hold_next = i_atr_pending && !auto_f;
    unique case (state_reg)
      NTH_S_IDLE: begin
        if (i_cmd_valid) begin
          cnt_next = 9'h000;
          pay_next = 9'h000;
          rxcmd_next = 1'b0;
          st_next = `NTH_ST_OK;
          state_next = i_cmd_last ? NTH_S_RESP : NTH_S_DRAIN;
          case (i_cmd_byte)
            `NTH_CMD_GB_LOAD: begin
              rsp_next = `NTH_RSP_GB_LOAD;
              gb_next = 1'b1;
              more_next = 1'b0;
              if (i_picc_active) begin
                st_next = `NTH_ST_SYNTAX;
              end else if (!i_atr_pending) begin
                st_next = `NTH_ST_BAD_STATE;
              end else if (auto_f) begin
                st_next = `NTH_ST_OK;
              end else if (i_cmd_last) begin
                as_next = 1'b1;
              end else begin
                state_next = NTH_S_FWD;
              end
            end
            `NTH_CMD_RECEIVE: begin
              rsp_next = `NTH_RSP_RECEIVE;
              if (i_released) begin
                st_next = `NTH_ST_RELEASED;
              end else if (!proto_ok) begin
                st_next = `NTH_ST_BAD_STATE;
              end else begin
                ack_next = 1'b1;
                rxcmd_next = 1'b1;
                state_next = NTH_S_RXWAIT;
              end
            end
            `NTH_CMD_SEND, `NTH_CMD_PARTIAL: begin
              gb_next = 1'b0;
              more_next = (i_cmd_byte == `NTH_CMD_PARTIAL);
              rsp_next = more_next ? `NTH_RSP_PARTIAL : `NTH_RSP_SEND;
              if (more_next && i_picc_active) begin
                st_next = `NTH_ST_SYNTAX;
              end else if (i_released) begin
                st_next = `NTH_ST_RELEASED;
              end else if (!(more_next ? i_dep_active : proto_ok)) begin
                st_next = `NTH_ST_BAD_STATE;
              end else if (i_cmd_last) begin
                te_next = 1'b1;
                tm_next = more_next;
                tgb_next = 1'b0;
              end else begin
                state_next = NTH_S_FWD;
              end
            end
            default: begin
              rsp_next = `NTH_RSP_UNKNOWN;
              st_next = `NTH_ST_SYNTAX;
            end
          endcase
        end
      end
      NTH_S_FWD: begin
        // Bytes stream straight to the RF framer; an overlong array is
        // cut with an abort once the bytes up to the limit have already gone out.
        if (i_cmd_valid) begin
          cnt_next = cnt_reg + 9'h001;
          if (cnt_reg == lim) begin
            ta_next = 1'b1;
            cnt_next = 9'h000;
            st_next = `NTH_ST_SYNTAX;
            state_next = i_cmd_last ? NTH_S_RESP : NTH_S_DRAIN;
          end else begin
            tv_next = 1'b1;
            tb_next = i_cmd_byte;
            tgb_next = gb_reg;
            if (i_cmd_last) begin
              cnt_next = 9'h000;
              as_next = gb_reg;
              te_next = !gb_reg;
              tm_next = more_reg;
              state_next = NTH_S_RESP;
            end
          end
        end
      end
      NTH_S_DRAIN: begin
        if (i_cmd_valid && i_cmd_last) begin
          state_next = NTH_S_RESP;
        end
      end
      NTH_S_RXWAIT: begin
        // Waits with no limit; the host owns any timeout
        if (rdy_reg && !wtx_reg) begin
          pay_next = flen_reg;
          st_next = `NTH_ST_OK;
          if (i_dep_active) begin
            st_next[`NTH_ST_NADDR_BIT] = naddr_reg;
            st_next[`NTH_ST_MINFO_BIT] = minfo_reg;
          end
          state_next = NTH_S_RESP;
        end
      end
      NTH_S_RESP: begin
        hv_next = !(hv_reg && hl_reg);
        if (cnt_reg >= 9'h002) begin
          mem_ra = cnt_reg - 9'h002;
        end
        if (cnt_reg == 9'h000) begin
          hb_next = rsp_reg;
        end else if (cnt_reg == 9'h001) begin
          hb_next = st_reg;
          hl_next = (pay_reg == 9'h000);
        end else begin
          hb_next = mem_rd;
          hl_next = (cnt_reg == pay_reg + 9'h001);
        end
        cnt_next = cnt_reg + 9'h001;
        if (hv_reg && hl_reg) begin
          hv_next = 1'b0;
          hl_next = 1'b0;
          cnt_next = 9'h000;
          rxcmd_next = 1'b0;
          state_next = NTH_S_IDLE;
        end
      end
      default: begin
        state_next = NTH_S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Register port
  // ==========================================================
  always_comb begin
    ctrl_next = ctrl_reg;
    rd_next = 16'h0000;
    if (i_reg_wr && i_reg_addr == `NTH_REG_CTRL) begin
      ctrl_next = i_reg_wdata[1:0];
    end
    if (i_reg_rd) begin
      if (i_reg_addr == `NTH_REG_CTRL) begin
        rd_next = {14'h0000, ctrl_reg};
      end else if (i_reg_addr == `NTH_REG_STATUS) begin
        rd_next = {st_reg, 5'h00, state_reg != NTH_S_IDLE, hold_reg,
                   rdy_reg};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= NTH_S_IDLE;
      rsp_reg <= 8'h00;
      st_reg <= 8'h00;
      cnt_reg <= 9'h000;
      pay_reg <= 9'h000;
      gb_reg <= 1'b0;
      more_reg <= 1'b0;
      rxcmd_reg <= 1'b0;
      hv_reg <= 1'b0;
      hb_reg <= 8'h00;
      hl_reg <= 1'b0;
      ack_reg <= 1'b0;
      tv_reg <= 1'b0;
      tb_reg <= 8'h00;
      tgb_reg <= 1'b0;
      te_reg <= 1'b0;
      tm_reg <= 1'b0;
      ta_reg <= 1'b0;
      as_reg <= 1'b0;
      hold_reg <= 1'b0;
      ac_reg <= 1'b0;
      wa_reg <= 9'h000;
      flen_reg <= 9'h000;
      rdy_reg <= 1'b0;
      naddr_reg <= 1'b0;
      minfo_reg <= 1'b0;
      wtx_reg <= 1'b0;
      tmr_reg <= 32'h0000_0000;
      ctrl_reg <= `NTH_CTRL_RESET;
      rd_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      rsp_reg <= rsp_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pay_reg <= pay_next;
      gb_reg <= gb_next;
      more_reg <= more_next;
      rxcmd_reg <= rxcmd_next;
      hv_reg <= hv_next;
      hb_reg <= hb_next;
      hl_reg <= hl_next;
      ack_reg <= ack_next;
      tv_reg <= tv_next;
      tb_reg <= tb_next;
      tgb_reg <= tgb_next;
      te_reg <= te_next;
      tm_reg <= tm_next;
      ta_reg <= ta_next;
      as_reg <= as_next;
      hold_reg <= hold_next;
      ac_reg <= ac_next;
      wa_reg <= wa_next;
      flen_reg <= flen_next;
      rdy_reg <= rdy_next;
      naddr_reg <= naddr_next;
      minfo_reg <= minfo_next;
      wtx_reg <= wtx_next;
      tmr_reg <= tmr_next;
      ctrl_reg <= ctrl_next;
      rd_reg <= rd_next;
    end
  end

  assign o_host_valid = hv_reg;
  assign o_host_byte = hb_reg;
  assign o_host_last = hl_reg;
  assign o_host_ack = ack_reg;
  assign o_rf_tx_valid = tv_reg;
  assign o_rf_tx_byte = tb_reg;
  assign o_rf_tx_gb = tgb_reg;
  assign o_rf_tx_end = te_reg;
  assign o_rf_tx_more = tm_reg;
  assign o_rf_tx_abort = ta_reg;
  assign o_atr_send = as_reg;
  assign o_atr_hold = hold_reg;
  assign o_wtx_req = wtx_reg;
  assign o_wtx_mult = `NTH_WTX_MULT;
  assign o_anticoll_restart = ac_reg;
  assign o_reg_rdata = rd_reg;
endmodule

// [nth_target_cmd_properties.sv]
// Port checker for the target-mode command handler.
// Assumes it is bound to nth_target_cmd and sees only its ports.
`timescale 1ns/1ps
`include "nth_regs.svh"
module nth_target_cmd_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_cmd_last,
  input wire logic o_host_valid,
  input wire logic o_host_last,
  input wire logic o_host_ack,
  input wire logic i_dep_active,
  input wire logic i_picc_active,
  input wire logic i_released,
  input wire logic i_rf_prop_frame,
  input wire logic o_rf_tx_valid,
  input wire logic o_rf_tx_gb,
  input wire logic o_rf_tx_end,
  input wire logic o_rf_tx_more,
  input wire logic o_rf_tx_abort,
  input wire logic o_atr_hold,
  input wire logic o_wtx_req,
  input wire logic [7:0] o_wtx_mult,
  input wire logic o_anticoll_restart,
  input wire logic [1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata
);
  // ==========================================================
  // Helper state: opcode of the current frame, shadow control
  logic in_frame_reg, in_frame_next;
  logic [7:0] op_reg, op_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic opc;
  assign opc = i_cmd_valid && !in_frame_reg;
  always_comb begin
    in_frame_next = i_cmd_valid ? !i_cmd_last : in_frame_reg;
    op_next = opc ? i_cmd_byte : op_reg;
    ctrl_next = ctrl_reg;
    if (i_reg_wr && i_reg_addr == `NTH_REG_CTRL) begin
      ctrl_next = i_reg_wdata[1:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_frame_reg <= 1'b0;
      op_reg <= 8'h00;
      ctrl_reg <= `NTH_CTRL_RESET;
    end else begin
      in_frame_reg <= in_frame_next;
      op_reg <= op_next;
      ctrl_reg <= ctrl_next;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rx_open;
    opc && i_cmd_last && i_cmd_byte == `NTH_CMD_RECEIVE && !i_released
      && (i_dep_active || i_picc_active);
  endsequence
  AST_RX_ACK: assert property (s_rx_open |-> ##[1:2] o_host_ack)
    else $error("receive not acknowledged");
  AST_WTX_MULT: assert property (o_wtx_mult == `NTH_WTX_MULT)
    else $error("wrong extension multiplier");
  AST_WTX_MODE: assert property (o_wtx_req |-> $past(i_dep_active || i_picc_active))
    else $error("extension outside an active mode");
  AST_RSP_RUN: assert property (o_host_valid && !o_host_last |=> o_host_valid)
    else $error("response bytes not back to back");
  AST_RSP_ONE: assert property (o_host_valid && o_host_last |=> !o_host_valid)
    else $error("extra response byte");
  AST_TX_MORE: assert property (o_rf_tx_end |-> o_rf_tx_more == (op_reg == `NTH_CMD_PARTIAL))
    else $error("more-information flag wrong");
  AST_TX_GB: assert property (o_rf_tx_valid |-> o_rf_tx_gb == (op_reg == `NTH_CMD_GB_LOAD))
    else $error("general byte flag wrong");
  AST_ABORT: assert property (o_rf_tx_abort |-> op_reg == `NTH_CMD_GB_LOAD)
    else $error("abort outside general-bytes load");
  AST_HOLD: assert property (o_atr_hold |-> !$past(ctrl_reg[`NTH_CTRL_AUTO_BIT]))
    else $error("attribute reply held with auto reply on");
  AST_ANTICOLL: assert property (i_rf_prop_frame && ctrl_reg[`NTH_CTRL_EXCL_BIT]
    |-> ##[1:2] o_anticoll_restart)
    else $error("anticollision not restarted");
  AST_RD_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
    else $error("read data not cleared");
  AST_RD_CTRL: assert property ($past(i_reg_rd && i_reg_addr == `NTH_REG_CTRL)
    |-> o_reg_rdata == {14'h0000, $past(ctrl_reg)})
    else $error("control read wrong");
endmodule

bind nth_target_cmd nth_target_cmd_chk i_nth_target_cmd_chk (.*);

// [nth_host_model.sv]
// Host controller model: sends one command frame at a time.
// Assumes the handler answers every frame; bench cuts any hang.
`timescale 1ns/1ps
module nth_host_model (
  input wire logic i_clk,
  input wire logic i_host_last,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_byte,
  output logic o_cmd_last
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte = 8'h00;
    o_cmd_last = 1'b0;
  end
  // Bytes back to back, opcode first; released byte line is inverted
  task automatic send(input logic [7:0] q[$]);
    int t;
    foreach (q[k]) begin
      @(posedge i_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_byte <= q[k];
      o_cmd_last <= (k == q.size() - 1);
    end
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_last <= 1'b0;
    o_cmd_byte <= ~q[q.size() - 1];
    t = 0;
    // Next command once the whole answer is out, or after 4000 cycles
    do begin
      @(posedge i_clk);
      t++;
    end while (i_host_last !== 1'b1 && t < 4000);
  endtask
endmodule

// [tb_nth_target_cmd.sv]
// Self-checking bench for the target-mode command handler.
// Assumes nth_regs.svh on the include path; extension period shortened.
`timescale 1ns/1ps
`include "nth_regs.svh"
module tb_nth_target_cmd;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cmd_valid, i_cmd_last, o_host_valid, o_host_last, o_host_ack;
  logic [7:0] i_cmd_byte, o_host_byte, o_rf_tx_byte, o_wtx_mult;
  logic [7:0] i_rf_rx_byte = 8'h00;
  logic i_dep_active = 1'b0, i_picc_active = 1'b0, i_released = 1'b0;
  logic i_atr_pending = 1'b0, i_rf_rx_valid = 1'b0, i_rf_rx_last = 1'b0;
  logic i_rf_rx_naddr = 1'b0, i_rf_rx_minfo = 1'b0, i_rf_prop_frame = 1'b0;
  logic o_rf_tx_valid, o_rf_tx_gb, o_rf_tx_end, o_rf_tx_more;
  logic o_rf_tx_abort, o_atr_send, o_atr_hold, o_wtx_req, o_anticoll_restart;
  logic [1:0] i_reg_addr = 2'h0;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [8:0] host_q[$], tx_q[$];
  logic [7:0] rf_q[$], cmd_q[$];
  logic [31:0] rng = 32'h00012EA3;
  logic tx_on = 1'b1;
  int fail_count = 0, samples_checked = 0, cyc = 0, b = 0;
  int n_wtx = 0, n_ack = 0, n_ac = 0, n_as = 0, n_ab = 0;

  nth_target_cmd #(.P_WTX_CYCLES(50)) i_nth_target_cmd (.*);
  nth_host_model i_nth_host_model (.i_clk(i_clk), .i_host_last(o_host_last),
    .o_cmd_valid(i_cmd_valid), .o_cmd_byte(i_cmd_byte),
    .o_cmd_last(i_cmd_last));

  always #12.5 i_clk = ~i_clk;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, e);
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  // Command with n random bytes; tk[1] expects them on RF, tk[0] as gb
  task automatic cmd(input logic [7:0] op, input int n,
      input logic [15:0] rsp, input logic [1:0] tk);
    logic [7:0] v;
    cmd_q = {op};
    repeat (n) begin
      v = rnd();
      cmd_q.push_back(v);
      if (tk[1]) tx_q.push_back({tk[0], v});
    end
    host_q.push_back({1'b0, rsp[15:8]});
    host_q.push_back({1'b1, rsp[7:0]});
    i_nth_host_model.send(cmd_q);
  endtask
  task automatic rf_send(input int n, input logic naddr, input logic minfo);
    rf_q = {};
    repeat (n) rf_q.push_back(rnd());
    foreach (rf_q[k]) begin
      @(posedge i_clk);
      i_rf_rx_valid <= 1'b1;
      i_rf_rx_byte <= rf_q[k];
      i_rf_rx_last <= (k == n - 1);
      i_rf_rx_naddr <= naddr;
      i_rf_rx_minfo <= minfo;
    end
    @(posedge i_clk);
    i_rf_rx_valid <= 1'b0;
    i_rf_rx_last <= 1'b0;
    i_rf_rx_byte <= ~rf_q[n - 1];
  endtask
  task automatic rx_exp(input logic [7:0] st);
    host_q.push_back({1'b0, `NTH_RSP_RECEIVE});
    host_q.push_back({rf_q.size() == 0, st});
    foreach (rf_q[k]) host_q.push_back({k == rf_q.size() - 1, rf_q[k]});
    rf_q = {};
  endtask
  task automatic rx(input logic [7:0] st);
    rx_exp(st);
    cmd_q = {`NTH_CMD_RECEIVE};
    i_nth_host_model.send(cmd_q);
  endtask

  // ==========================================================
  // Output watcher: oldest note against each result
  always @(posedge i_clk) begin
    cyc++;
    n_wtx += (o_wtx_req === 1'b1);
    n_ab += (o_rf_tx_abort === 1'b1);
    n_ack += (o_host_ack === 1'b1);
    n_ac += (o_anticoll_restart === 1'b1);
    n_as += (o_atr_send === 1'b1);
    if (o_host_valid === 1'b1) begin
      chk({o_host_last, o_host_byte}, host_q.size() ? host_q.pop_front() : 16'hFFFF);
    end
    if (o_rf_tx_valid === 1'b1 && tx_on) begin
      chk({o_rf_tx_gb, o_rf_tx_byte}, tx_q.size() ? tx_q.pop_front() : 16'hFFFF);
    end
    // Hang guard last, so nothing runs after the run ends
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    tick(5);
    i_rst_n <= 1'b1;
    tick(1);
    #1 chk(o_wtx_mult, `NTH_WTX_MULT);
    rd(`NTH_REG_CTRL, 16'h0001);
    rd(2'h3, 16'h0000);
    wr(`NTH_REG_STATUS, 16'hFFFF);
    rd(`NTH_REG_STATUS, 16'h0000);
    rx(`NTH_ST_BAD_STATE);
    i_released <= 1'b1;
    i_dep_active <= 1'b1;
    rx(`NTH_ST_RELEASED);
    i_released <= 1'b0;
    b = n_wtx;
    rf_send(3, 1'b1, 1'b1);
    tick(2);
    chk(n_wtx - b, 1);
    b = n_ack;
    rx(8'hC0);
    chk(n_ack - b, 1);
    b = n_ack;
    fork
      begin
        cmd_q = {`NTH_CMD_RECEIVE};
        i_nth_host_model.send(cmd_q);
      end
      begin
        tick(40);
        rf_send(2, 1'b0, 1'b0);
        rx_exp(`NTH_ST_OK);
      end
    join
    chk(n_ack - b, 1);
    cmd(`NTH_CMD_SEND, 262, {`NTH_RSP_SEND, `NTH_ST_OK}, 2'b10);
    cmd(`NTH_CMD_SEND, 0, {`NTH_RSP_SEND, `NTH_ST_OK}, 2'b10);
    cmd(`NTH_CMD_PARTIAL, 3, {`NTH_RSP_PARTIAL, `NTH_ST_OK}, 2'b10);
    i_dep_active <= 1'b0;
    i_picc_active <= 1'b1;
    b = n_wtx;
    rf_send(2, 1'b0, 1'b0);
    tick(2);
    chk(n_wtx - b, 1);
    rx(`NTH_ST_OK);
    cmd(`NTH_CMD_PARTIAL, 2, {`NTH_RSP_PARTIAL, `NTH_ST_SYNTAX}, 2'b00);
    cmd(`NTH_CMD_GB_LOAD, 2, {`NTH_RSP_GB_LOAD, `NTH_ST_SYNTAX}, 2'b00);
    cmd(`NTH_CMD_SEND, 4, {`NTH_RSP_SEND, `NTH_ST_OK}, 2'b10);
    i_picc_active <= 1'b0;
    i_dep_active <= 1'b1;
    i_atr_pending <= 1'b1;
    tick(2);
    chk(o_atr_hold, 0);
    cmd(`NTH_CMD_GB_LOAD, 3, {`NTH_RSP_GB_LOAD, `NTH_ST_OK}, 2'b00);
    wr(`NTH_REG_CTRL, 16'h0000);
    tick(2);
    chk(o_atr_hold, 1);
    b = n_as;
    cmd(`NTH_CMD_GB_LOAD, 47, {`NTH_RSP_GB_LOAD, `NTH_ST_OK}, 2'b11);
    chk(n_as - b, 1);
    tx_on = 1'b0;
    b = n_ab;
    cmd(`NTH_CMD_GB_LOAD, 48, {`NTH_RSP_GB_LOAD, `NTH_ST_SYNTAX}, 2'b00);
    chk(n_ab - b, 1);
    tx_on = 1'b1;
    i_atr_pending <= 1'b0;
    cmd(`NTH_CMD_GB_LOAD, 1, {`NTH_RSP_GB_LOAD, `NTH_ST_BAD_STATE}, 2'b00);
    wr(`NTH_REG_CTRL, 16'h0002);
    rd(`NTH_REG_CTRL, 16'h0002);
    b = n_ac;
    @(posedge i_clk);
    i_rf_prop_frame <= 1'b1;
    @(posedge i_clk);
    i_rf_prop_frame <= 1'b0;
    tick(3);
    chk(n_ac - b, 1);
    tick(4);
    chk(host_q.size(), 0);
    chk(tx_q.size(), 0);
    wrap_up();
  end
endmodule
